/* File: shared/vsw_defines.svh */
`ifndef VSW_DEFINES_SVH
`define VSW_DEFINES_SVH
// ****************************************
// register offsets
// ****************************************
`define VSW_OFS_FAST 8'h00
`define VSW_OFS_SIDE 8'h01
`define VSW_OFS_RECV 8'h10
`define VSW_OFS_TPAB 8'h11
`define VSW_OFS_TPCD 8'h12
`define VSW_OFS_EQAB 8'h13
`define VSW_OFS_EQCD 8'h14
`define VSW_OFS_TX 8'h20
// ****************************************
// reset values and writable bits
// ****************************************
`define VSW_RST_FAST 8'h40
`define VSW_RST_SIDE 8'h40
`define VSW_RST_RECV 8'h01
`define VSW_RST_ZERO 8'h00
`define VSW_RST_TX 8'h03
`define VSW_MSK_MODES 8'h7F
`define VSW_MSK_RECV 8'h01
`define VSW_MSK_FULL 8'hFF
`define VSW_MSK_TX 8'h0F
// ****************************************
// fields
// ****************************************
`define VSW_EN_BIT 6
`define VSW_MODE_BAD 2'h3
`define VSW_ADDR_UPPER 4'h9
// ****************************************
// timing
// ****************************************
`define VSW_CLK_NS 25
`define VSW_FAST_DLY_NS 200
`define VSW_ANA_DLY_NS 1000
`define VSW_FAST_DLY_CYC ((`VSW_FAST_DLY_NS + `VSW_CLK_NS - 1) / `VSW_CLK_NS)
`define VSW_ANA_DLY_CYC ((`VSW_ANA_DLY_NS + `VSW_CLK_NS - 1) / `VSW_CLK_NS)
`endif

/* File: shared/vsw_pkg.sv */
package vsw_pkg;
  typedef logic [7:0] vsw_byte_t;
  typedef enum logic [1:0] {
    VSW_QUAD = 2'h0,
    VSW_DUAL = 2'h1,
    VSW_SINGLE = 2'h2
  } vsw_bundle_e;
  typedef enum logic [8:0] {
    VSW_IDLE = 9'h001,
    VSW_ADDR = 9'h002,
    VSW_ACKA = 9'h004,
    VSW_REG = 9'h008,
    VSW_ACKR = 9'h010,
    VSW_WDATA = 9'h020,
    VSW_ACKW = 9'h040,
    VSW_RDATA = 9'h080,
    VSW_RACK = 9'h100
  } vsw_i2c_e;
endpackage

/* File: shared/vsw_win_if.sv */
`timescale 1ns/100ps
interface vsw_win_if #(parameter int W = 8) ();
  logic [W-1:0] target;
  logic [W-1:0] applied;
  modport src (output target, input applied);
  modport win (input target, output applied);
endinterface

/* File: logic/vsw_sync.sv */
`timescale 1ns/100ps
module vsw_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  import vsw_pkg::*;
  logic [W-1:0] meta_r;
  logic [W-1:0] q_r;
  // first stage feeds only the second
  always_ff @(posedge clk) begin
    meta_r <= d;
    q_r <= meta_r;
  end
  assign q = q_r;
endmodule

/* File: logic/vsw_update_window.sv */
`timescale 1ns/100ps
module vsw_update_window #(
  parameter int W = 8,
  parameter logic [W-1:0] RST_VAL = '0,
  parameter int DLY_CYC = 8
) (
  input wire logic clk,
  input wire logic rst,
  vsw_win_if.win w
);
  import vsw_pkg::*;
  localparam int CW = $clog2(DLY_CYC + 1);
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic [W-1:0] app_r;
  logic [W-1:0] app_nxt;

  // later writes overwrite target; a running window is not restarted by them
  always_comb begin
    cnt_nxt = cnt_r;
    app_nxt = app_r;
    if (cnt_r != '0) begin
      cnt_nxt = cnt_r - 1'b1;
    end else if (w.target != app_r) begin
      app_nxt = w.target;
      cnt_nxt = CW'(DLY_CYC);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_r <= '0;
      app_r <= RST_VAL;
    end else begin
      cnt_r <= cnt_nxt;
      app_r <= app_nxt;
    end
  end
  assign w.applied = app_r;

  window_hold_a: assert property (
    @(posedge clk) disable iff (rst) cnt_r != '0 |=> $stable(app_r))
    else $error("setting changed inside delay window");
  window_start_a: assert property (
    @(posedge clk) disable iff (rst) cnt_r == '0 && w.target != app_r
    |=> app_r == $past(w.target) && cnt_r == CW'(DLY_CYC))
    else $error("idle window did not apply and restart");
endmodule

/* File: logic/vsw_config_regs.sv */
`timescale 1ns/100ps
`include "vsw_defines.svh"
module vsw_config_regs #(
  parameter int FAST_DLY_CYC = `VSW_FAST_DLY_CYC,
  parameter int ANA_DLY_CYC = `VSW_ANA_DLY_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic i2cClk,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOeN,
  input wire logic busAddrStrap2,
  input wire logic busAddrStrap1,
  input wire logic busAddrStrap0,
  input wire logic pinLaneEnable,
  input wire logic [1:0] pinSourceSelect,
  input wire logic pinEqualizerLevel,
  input wire logic [1:0] pinEmphasisLevel,
  input wire logic pinOutputTermination,
  input wire logic pinOutputCurrent,
  output logic serialControl,
  output logic fastLaneEnable,
  output vsw_pkg::vsw_bundle_e fastBundleMode,
  output logic [3:0] fastSourceSelect,
  output logic [15:0] fastLaneRoute,
  output logic inputTermSelect,
  output logic [15:0] inputTermPulse,
  output logic [15:0] inputEqLevel,
  output logic [1:0] outputEmphasisLevel,
  output logic outputTermSelect,
  output logic outputCurrentLevel
);
  import vsw_pkg::*;

  // ****************************************
  // constants and decoding
  // ****************************************
  localparam vsw_byte_t WMASK [8] = '{`VSW_MSK_MODES, `VSW_MSK_MODES, `VSW_MSK_RECV,
    `VSW_MSK_FULL, `VSW_MSK_FULL, `VSW_MSK_FULL, `VSW_MSK_FULL, `VSW_MSK_TX};
  localparam vsw_byte_t RSTV [8] = '{`VSW_RST_FAST, `VSW_RST_SIDE, `VSW_RST_RECV,
    `VSW_RST_ZERO, `VSW_RST_ZERO, `VSW_RST_ZERO, `VSW_RST_ZERO, `VSW_RST_TX};

  // bit 3 flags a mapped address, bits 2:0 index the storage
  function automatic logic [3:0] regSlot(input vsw_byte_t a);
    case (a)
      `VSW_OFS_FAST: regSlot = 4'h8;
      `VSW_OFS_SIDE: regSlot = 4'h9;
      `VSW_OFS_RECV: regSlot = 4'hA;
      `VSW_OFS_TPAB: regSlot = 4'hB;
      `VSW_OFS_TPCD: regSlot = 4'hC;
      `VSW_OFS_EQAB: regSlot = 4'hD;
      `VSW_OFS_EQCD: regSlot = 4'hE;
      `VSW_OFS_TX: regSlot = 4'hF;
      default: regSlot = 4'h0;
    endcase
  endfunction

  // lane index 0..15 stands for A0..D3
  function automatic logic [3:0] laneFor(input logic [1:0] mode, input logic [3:0] sel,
    input logic [1:0] outIdx);
    case (mode)
      VSW_DUAL: laneFor = {sel[2:0], outIdx[1]};
      VSW_SINGLE: laneFor = sel;
      default: laneFor = {sel[1:0], outIdx};
    endcase
  endfunction

  // ****************************************
  // link side: two-wire slave and register storage
  // ****************************************
  logic [4:0] linkS;
  logic rstLink;
  logic sclS;
  logic sdaS;
  logic [2:0] strapS;
  logic sclD_r;
  logic sdaD_r;
  vsw_i2c_e st_r;
  vsw_i2c_e st_nxt;
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  vsw_byte_t shift_r;
  vsw_byte_t shift_nxt;
  vsw_byte_t ptr_r;
  vsw_byte_t ptr_nxt;
  vsw_byte_t regs_r [8];
  vsw_byte_t regs_nxt [8];
  vsw_byte_t rdata;
  vsw_byte_t wv;
  logic [3:0] slot;
  logic sdaOeN_r;
  logic sdaOeN_nxt;
  logic dirty_r;
  logic dirty_nxt;
  logic snapReq_r;
  logic snapReq_nxt;
  logic [55:0] snap_r;
  logic [55:0] snap_nxt;
  logic ackS;
  logic startEv;
  logic stopEv;
  logic sclRise;
  logic sclFall;
  logic addrHit;
  logic wrEv;
  logic reqSeen_r;

  vsw_sync #(.W(1)) uRstLink (.clk(i2cClk), .d(rst), .q(rstLink));
  vsw_sync #(.W(5)) uLinkPins (
    .clk(i2cClk),
    .d({sclIn, sdaIn, busAddrStrap2, busAddrStrap1, busAddrStrap0}),
    .q(linkS)
  );
  vsw_sync #(.W(1)) uAck (.clk(i2cClk), .d(reqSeen_r), .q(ackS));

  assign sclS = linkS[4];
  assign sdaS = linkS[3];
  assign strapS = linkS[2:0];
  assign startEv = sclS && sclD_r && sdaD_r && !sdaS;
  assign stopEv = sclS && sclD_r && !sdaD_r && sdaS;
  assign sclRise = sclS && !sclD_r;
  assign sclFall = !sclS && sclD_r;
  assign addrHit = shift_r[7:1] == {`VSW_ADDR_UPPER, strapS};

  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    shift_nxt = shift_r;
    ptr_nxt = ptr_r;
    sdaOeN_nxt = sdaOeN_r;
    regs_nxt = regs_r;
    snapReq_nxt = snapReq_r;
    snap_nxt = snap_r;
    wrEv = 1'b0;
    slot = regSlot(ptr_r);
    rdata = slot[3] ? regs_r[slot[2:0]] : 8'h00;
    wv = shift_r & WMASK[slot[2:0]];
    if (slot[2:1] == 2'h0 && wv[5:4] == `VSW_MODE_BAD) begin
      wv[5:4] = regs_r[slot[2:0]][5:4];
    end
    if (startEv) begin
      st_nxt = VSW_ADDR;
      cnt_nxt = 4'h0;
      sdaOeN_nxt = 1'b1;
    end else if (stopEv) begin
      st_nxt = VSW_IDLE;
      sdaOeN_nxt = 1'b1;
    end else begin
      case (st_r)
        VSW_ADDR, VSW_REG, VSW_WDATA: begin
          if (sclRise) begin
            shift_nxt = {shift_r[6:0], sdaS};
            cnt_nxt = cnt_r + 4'h1;
          end else if (sclFall && cnt_r == 4'h8) begin
            cnt_nxt = 4'h0;
            sdaOeN_nxt = 1'b0;
            if (st_r == VSW_ADDR) begin
              st_nxt = addrHit ? VSW_ACKA : VSW_IDLE;
              sdaOeN_nxt = !addrHit;
            end else if (st_r == VSW_REG) begin
              ptr_nxt = shift_r;
              st_nxt = VSW_ACKR;
            end else begin
              if (slot[3]) begin
                regs_nxt[slot[2:0]] = wv;
              end
              wrEv = 1'b1;
              st_nxt = VSW_ACKW;
            end
          end
        end
        VSW_ACKA: begin
          if (sclFall) begin
            st_nxt = shift_r[0] ? VSW_RDATA : VSW_REG;
            shift_nxt = rdata;
            sdaOeN_nxt = shift_r[0] ? rdata[7] : 1'b1;
          end
        end
        VSW_ACKR, VSW_ACKW: begin
          if (sclFall) begin
            st_nxt = VSW_WDATA;
            sdaOeN_nxt = 1'b1;
          end
        end
        VSW_RDATA: begin
          if (sclRise) begin
            cnt_nxt = cnt_r + 4'h1;
          end else if (sclFall && cnt_r == 4'h8) begin
            cnt_nxt = 4'h0;
            sdaOeN_nxt = 1'b1;
            st_nxt = VSW_RACK;
          end else if (sclFall) begin
            shift_nxt = {shift_r[6:0], 1'b0};
            sdaOeN_nxt = shift_r[6];
          end
        end
        VSW_RACK: begin
          if (sclRise && sdaS) begin
            st_nxt = VSW_IDLE;
          end else if (sclFall) begin
            st_nxt = VSW_RDATA;
            shift_nxt = rdata;
            sdaOeN_nxt = rdata[7];
          end
        end
        default: st_nxt = VSW_IDLE;
      endcase
    end
    // a write landing while a snapshot leaves keeps the dirty flag set
    dirty_nxt = dirty_r || wrEv || (st_nxt == VSW_ACKA && st_r == VSW_ADDR);
    if (dirty_r && snapReq_r == ackS) begin
      snap_nxt = {regs_r[7], regs_r[6], regs_r[5], regs_r[4], regs_r[3], regs_r[2],
        regs_r[0]};
      snapReq_nxt = !snapReq_r;
      dirty_nxt = wrEv || (st_nxt == VSW_ACKA && st_r == VSW_ADDR);
    end
  end

  always_ff @(posedge i2cClk) begin
    sclD_r <= sclS;
    sdaD_r <= sdaS;
    if (rstLink) begin
      st_r <= VSW_IDLE;
      cnt_r <= 4'h0;
      shift_r <= 8'h00;
      ptr_r <= 8'h00;
      regs_r <= RSTV;
      sdaOeN_r <= 1'b1;
      dirty_r <= 1'b0;
      snapReq_r <= 1'b0;
      snap_r <= '0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      shift_r <= shift_nxt;
      ptr_r <= ptr_nxt;
      regs_r <= regs_nxt;
      sdaOeN_r <= sdaOeN_nxt;
      dirty_r <= dirty_nxt;
      snapReq_r <= snapReq_nxt;
      snap_r <= snap_nxt;
    end
  end
  assign sdaOut = 1'b0;
  assign sdaOeN = sdaOeN_r;

  // ****************************************
  // core side: source arbitration and routing
  // ****************************************
  logic [7:0] pinS;
  logic reqS;
  logic reqSeen_nxt;
  logic newSnap;
  logic serialMode_r;
  logic serialMode_nxt;
  logic [55:0] snapClk_r;
  logic [55:0] snapClk_nxt;
  logic laneEn_r;
  logic laneEn_nxt;
  logic [15:0] route_r;
  logic [15:0] route_nxt;
  vsw_byte_t parFast;
  logic [47:0] parAna;
  vsw_win_if #(.W(8)) fastW ();
  vsw_win_if #(.W(48)) anaW ();

  vsw_sync #(.W(8)) uPins (
    .clk(clk),
    .d({pinLaneEnable, pinSourceSelect, pinEqualizerLevel, pinEmphasisLevel,
      pinOutputTermination, pinOutputCurrent}),
    .q(pinS)
  );
  vsw_sync #(.W(1)) uReq (.clk(clk), .d(snapReq_r), .q(reqS));

  // pins only offer quad bundling
  assign parFast = {1'b0, pinS[7], 4'h0, pinS[6:5]};
  assign parAna = {4'h0, pinS[3:0], {16{pinS[4]}}, 16'h0000, `VSW_RST_RECV};
  assign fastW.target = serialMode_r ? snapClk_r[7:0] : parFast;
  assign anaW.target = serialMode_r ? snapClk_r[55:8] : parAna;

  vsw_update_window #(.W(8), .RST_VAL(`VSW_RST_FAST), .DLY_CYC(FAST_DLY_CYC)) uFastWin (
    .clk(clk),
    .rst(rst),
    .w(fastW.win)
  );
  vsw_update_window #(
    .W(48),
    .RST_VAL({`VSW_RST_TX, 32'h0000_0000, `VSW_RST_RECV}),
    .DLY_CYC(ANA_DLY_CYC)
  ) uAnaWin (
    .clk(clk),
    .rst(rst),
    .w(anaW.win)
  );

  for (genvar g = 0; g < 4; g++) begin : gRoute
    assign route_nxt[4*g +: 4] = laneFor(fastW.applied[5:4], fastW.applied[3:0], 2'(g));
  end

  // snap_r is steady while the toggle is in flight
  always_comb begin
    newSnap = reqS != reqSeen_r;
    reqSeen_nxt = reqS;
    serialMode_nxt = serialMode_r || newSnap;
    snapClk_nxt = newSnap ? snap_r : snapClk_r;
    laneEn_nxt = fastW.applied[`VSW_EN_BIT];
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      reqSeen_r <= 1'b0;
      serialMode_r <= 1'b0;
      snapClk_r <= '0;
      laneEn_r <= 1'b0;
      route_r <= 16'h0000;
    end else begin
      reqSeen_r <= reqSeen_nxt;
      serialMode_r <= serialMode_nxt;
      snapClk_r <= snapClk_nxt;
      laneEn_r <= laneEn_nxt;
      route_r <= route_nxt;
    end
  end

  assign serialControl = serialMode_r;
  assign fastLaneEnable = laneEn_r;
  assign fastBundleMode = vsw_bundle_e'(fastW.applied[5:4]);
  assign fastSourceSelect = fastW.applied[3:0];
  assign fastLaneRoute = route_r;
  assign inputTermSelect = anaW.applied[0];
  assign inputTermPulse = anaW.applied[23:8];
  assign inputEqLevel = anaW.applied[39:24];
  assign outputCurrentLevel = anaW.applied[40];
  assign outputTermSelect = anaW.applied[41];
  assign outputEmphasisLevel = anaW.applied[43:42];

  // ****************************************
  // checks
  // ****************************************
  pin_source_a: assert property (
    @(posedge clk) disable iff (rst) !serialMode_r
    |-> fastW.target[`VSW_EN_BIT] == pinS[7] && fastW.target[5:0] == {4'h0, pinS[6:5]})
    else $error("pin image not steering config");
  serial_source_a: assert property (
    @(posedge clk) disable iff (rst) serialMode_r && !newSnap
    |=> $stable(fastW.target) && $stable(anaW.target))
    else $error("pins steer config under serial control");
  serial_sticky_a: assert property (
    @(posedge clk) disable iff (rst) $rose(serialMode_r) |=> serialMode_r [*8])
    else $error("serial control dropped before reset");
  lane_off_a: assert property (
    @(posedge clk) disable iff (rst) !fastW.applied[`VSW_EN_BIT] |=> !fastLaneEnable)
    else $error("lanes left on while disabled");
  route_quad_a: assert property (
    @(posedge clk) disable iff (rst) fastW.applied[5:4] == 2'h0 |=> route_r ==
    {$past(fastW.applied[1:0]), 2'h3, $past(fastW.applied[1:0]), 2'h2,
    $past(fastW.applied[1:0]), 2'h1, $past(fastW.applied[1:0]), 2'h0})
    else $error("quad route wrong");
  route_dual_a: assert property (
    @(posedge clk) disable iff (rst) fastW.applied[5:4] == 2'h1 |=> route_r ==
    {$past(fastW.applied[2:0]), 1'b1, $past(fastW.applied[2:0]), 1'b1,
    $past(fastW.applied[2:0]), 1'b0, $past(fastW.applied[2:0]), 1'b0})
    else $error("dual route wrong");
  route_single_a: assert property (
    @(posedge clk) disable iff (rst) fastW.applied[5:4] == 2'h2
    |=> route_r == {4{$past(fastW.applied[3:0])}})
    else $error("single route wrong");
  addr_ack_a: assert property (
    @(posedge i2cClk) disable iff (rstLink) st_r == VSW_ADDR && sclFall && cnt_r == 4'h8
    && shift_r[7:1] == {`VSW_ADDR_UPPER, strapS} |=> !sdaOeN_r && st_r == VSW_ACKA)
    else $error("own address not acknowledged");
  addr_miss_a: assert property (
    @(posedge i2cClk) disable iff (rstLink) st_r == VSW_ADDR && sclFall && cnt_r == 4'h8
    && shift_r[7:4] != `VSW_ADDR_UPPER |=> sdaOeN_r && st_r == VSW_IDLE)
    else $error("foreign address acknowledged");
  mode_legal_a: assert property (
    @(posedge i2cClk) disable iff (rst || rstLink)
    regs_r[0][5:4] != `VSW_MODE_BAD && regs_r[1][5:4] != `VSW_MODE_BAD)
    else $error("illegal bundling mode stored");
  reserved_zero_a: assert property (
    @(posedge i2cClk) disable iff (rst || rstLink)
    regs_r[0][7] == 1'b0 && regs_r[2][7:1] == 7'h00 && regs_r[7][7:4] == 4'h0)
    else $error("undefined bits not zero");
  write_lands_a: assert property (
    @(posedge i2cClk) disable iff (rstLink) st_r == VSW_WDATA && sclFall && cnt_r == 4'h8
    && regSlot(ptr_r) == 4'h8 |=> regs_r[0][`VSW_EN_BIT] == $past(shift_r[6]))
    else $error("register write lost");
  unmapped_read_a: assert property (
    @(posedge i2cClk) disable iff (rstLink) st_r == VSW_ACKA && sclFall && shift_r[0]
    && regSlot(ptr_r) < 4'h8 |=> shift_r == 8'h00 && !sdaOeN_r)
    else $error("unmapped read not zero");
  takeover_c: cover property (@(posedge clk) disable iff (rst) $rose(serialMode_r));
  single_c: cover property (@(posedge clk) disable iff (rst) fastW.applied[5:4] == 2'h2);
  read_c: cover property (@(posedge i2cClk) disable iff (rstLink) st_r == VSW_RACK);
endmodule

/* File: test/vsw_i2c_master.sv */
`timescale 1ns/100ps
module vsw_i2c_master (
  input wire logic clk,
  input wire logic sdaOeN,
  input wire logic sdaOut,
  output logic sclLine,
  output logic sdaLine
);
  logic sclLow;
  logic sdaLow;
  initial begin
    sclLow = 1'b0;
    sdaLow = 1'b0;
  end
  // both lines pulled up; released means high, never the last value
  assign sclLine = ~sclLow;
  assign sdaLine = sdaLow ? 1'b0 : (sdaOeN ? 1'b1 : sdaOut);
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  // scl high and low each four core cycles, well over six link cycles
  task automatic bus_start();
    tick(2);
    sdaLow = 1'b0;
    tick(2);
    sclLow = 1'b0;
    tick(4);
    sdaLow = 1'b1;
    tick(4);
    sclLow = 1'b1;
  endtask
  task automatic bus_stop();
    tick(2);
    sdaLow = 1'b1;
    tick(2);
    sclLow = 1'b0;
    tick(4);
    sdaLow = 1'b0;
    tick(4);
  endtask
  // data moves two cycles after the fall, sampled at the end of high
  task automatic clock_bit(input logic b, output logic seen);
    tick(2);
    sdaLow = ~b;
    tick(2);
    sclLow = 1'b0;
    tick(4);
    seen = sdaLine;
    sclLow = 1'b1;
  endtask
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clock_bit(d[i], s);
    end
    clock_bit(1'b1, s);
    ack = ~s;
  endtask
  task automatic recv_byte(input logic nack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clock_bit(1'b1, d[i]);
    end
    clock_bit(nack, s);
  endtask
endmodule

/* File: test/vsw_config_regs_tb_top.sv */
`timescale 1ns/100ps
module vsw_config_regs_tb_top;
  import vsw_pkg::*;
  localparam int FDLY = 100;
  localparam int ADLY = 8;
  localparam int LIMIT = 80000;
  localparam logic [2:0] STRAP = 3'b101;
  localparam logic [6:0] DEV = {4'h9, STRAP};
  logic clk, rst, i2cClk, scl, sda, sdaOut, sdaOeN, serialControl, fastLaneEnable;
  logic pinLaneEnable, pinEqualizerLevel, pinOutputTermination, pinOutputCurrent;
  logic [1:0] pinSourceSelect, pinEmphasisLevel, outputEmphasisLevel;
  vsw_bundle_e fastBundleMode;
  logic [3:0] fastSourceSelect;
  logic [15:0] fastLaneRoute, inputTermPulse, inputEqLevel;
  logic inputTermSelect, outputTermSelect, outputCurrentLevel;
  int num_errors = 0;
  int n_checks = 0;
  int cyc = 0;
  logic [6:0] bad [4] = '{7'h4C, 7'h4F, 7'h49, 7'h1D};
  logic [7:0] ra [8] = '{8'h01, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h20, 8'h30};
  logic [7:0] rv [8] = '{8'h40, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h03, 8'h00};
  logic [7:0] wv [8] = '{8'hFF, 8'hFE, 8'hA5, 8'h5A, 8'h3C, 8'hC3, 8'hFF, 8'h77};
  logic [7:0] ev [8] = '{8'h4F, 8'h00, 8'hA5, 8'h5A, 8'h3C, 8'hC3, 8'h0F, 8'h00};

  vsw_config_regs #(.FAST_DLY_CYC(FDLY), .ANA_DLY_CYC(ADLY)) dut (
    .clk(clk), .rst(rst), .i2cClk(i2cClk), .sclIn(scl), .sdaIn(sda),
    .sdaOut(sdaOut), .sdaOeN(sdaOeN), .busAddrStrap2(STRAP[2]),
    .busAddrStrap1(STRAP[1]), .busAddrStrap0(STRAP[0]), .pinLaneEnable(pinLaneEnable),
    .pinSourceSelect(pinSourceSelect), .pinEqualizerLevel(pinEqualizerLevel),
    .pinEmphasisLevel(pinEmphasisLevel), .pinOutputTermination(pinOutputTermination),
    .pinOutputCurrent(pinOutputCurrent), .serialControl(serialControl),
    .fastLaneEnable(fastLaneEnable), .fastBundleMode(fastBundleMode),
    .fastSourceSelect(fastSourceSelect), .fastLaneRoute(fastLaneRoute),
    .inputTermSelect(inputTermSelect), .inputTermPulse(inputTermPulse),
    .inputEqLevel(inputEqLevel), .outputEmphasisLevel(outputEmphasisLevel),
    .outputTermSelect(outputTermSelect), .outputCurrentLevel(outputCurrentLevel));
  vsw_i2c_master mst (.clk(clk), .sdaOeN(sdaOeN), .sdaOut(sdaOut), .sclLine(scl),
    .sdaLine(sda));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // link clock unrelated in phase to the core clock
  initial begin
    i2cClk = 1'b0;
    #3.1;
    forever #6 i2cClk = ~i2cClk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == LIMIT) begin
      num_errors++;
      tally_and_finish();
    end
  end

  // ****************************************
  // helpers
  // ****************************************
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic put(input logic [7:0] d);
    logic ack;
    mst.send_byte(d, ack);
    check("byte ack", ack, 1'b1);
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    mst.bus_start();
    put({DEV, 1'b0});
    put(a);
    put(d);
    mst.bus_stop();
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    mst.bus_start();
    put({DEV, 1'b0});
    put(a);
    mst.bus_start();
    put({DEV, 1'b1});
    mst.recv_byte(1'b1, d);
    mst.bus_stop();
    check("reg read", d, e);
  endtask
  // long enough for either update window to run out
  task automatic settle();
    repeat (FDLY + 12) @(negedge clk);
  endtask
  function automatic logic [15:0] exp_route(input int m, input int s);
    logic [15:0] r;
    int lane;
    for (int k = 0; k < 4; k++) begin
      if (m == 0) lane = (s % 4) * 4 + k;
      else if (m == 1) lane = (s % 8) * 2 + k / 2;
      else lane = s;
      r[k*4 +: 4] = lane[3:0];
    end
    return r;
  endfunction

  // ****************************************
  // sequence
  // ****************************************
  initial begin
    logic ack;
    logic [7:0] rb;
    int w, k;
    rst = 1'b1;
    pinLaneEnable = 1'b0;
    pinSourceSelect = 2'h0;
    pinEqualizerLevel = 1'b0;
    pinEmphasisLevel = 2'h0;
    pinOutputTermination = 1'b1;
    pinOutputCurrent = 1'b1;
    repeat (16) @(negedge clk);
    rst = 1'b0;
    repeat (8) @(negedge clk);
    check("sda released", sdaOeN, 1'b1);
    check("sda value", sdaOut, 1'b0);
    check("pin control", serialControl, 1'b0);
    pinLaneEnable = 1'b1;
    pinSourceSelect = 2'h2;
    pinEqualizerLevel = 1'b1;
    pinEmphasisLevel = 2'h2;
    pinOutputTermination = 1'b0;
    pinOutputCurrent = 1'b0;
    settle();
    check("pin enable", fastLaneEnable, 1'b1);
    check("pin route", fastLaneRoute, 16'hBA98);
    check("pin eq", inputEqLevel, 16'hFFFF);
    check("pin tx", {outputEmphasisLevel, outputTermSelect, outputCurrentLevel}, 4'h8);
    pinSourceSelect = 2'h3;
    settle();
    check("pin route 2", fastLaneRoute, 16'hFEDC);
    $display("test pins done");
    for (int i = 0; i < 4; i++) begin
      mst.bus_start();
      mst.send_byte({bad[i], 1'b0}, ack);
      check("foreign ack", ack, 1'b0);
      mst.bus_stop();
    end
    check("still pins", serialControl, 1'b0);
    $display("test address done");
    rd_chk(8'h00, 8'h40);
    pinLaneEnable = 1'b0;
    pinSourceSelect = 2'h1;
    settle();
    check("serial mode", serialControl, 1'b1);
    check("pins ignored", fastLaneEnable, 1'b1);
    check("serial route", fastLaneRoute, 16'h3210);
    check("serial tx", {outputEmphasisLevel, outputTermSelect, outputCurrentLevel}, 4'h3);
    for (int i = 0; i < 8; i++) begin
      rd_chk(ra[i], rv[i]);
      wr_reg(ra[i], wv[i]);
      rd_chk(ra[i], ev[i]);
    end
    settle();
    check("term pulse", inputTermPulse, 16'h5AA5);
    check("eq level", inputEqLevel, 16'hC33C);
    check("tx", {outputEmphasisLevel, outputTermSelect, outputCurrentLevel}, 4'hF);
    check("term select", inputTermSelect, 1'b0);
    $display("test registers done");
    for (int m = 0; m < 3; m++) begin
      for (int s = 0; s < 16; s++) begin
        wr_reg(8'h00, {2'b01, m[1:0], s[3:0]});
        settle();
        check("mode", fastBundleMode, m[1:0]);
        check("select", {fastLaneEnable, fastSourceSelect}, {1'b1, s[3:0]});
        check("route", fastLaneRoute, exp_route(m, s));
      end
    end
    $display("test routing done");
    wr_reg(8'h00, 8'h3A);
    settle();
    check("bad mode", fastBundleMode, VSW_SINGLE);
    check("lanes off", fastLaneEnable, 1'b0);
    check("single route", fastLaneRoute, 16'hAAAA);
    rd_chk(8'h00, 8'h2A);
    // master acks the first byte so the same register is sent again
    mst.bus_start();
    put({DEV, 1'b1});
    mst.recv_byte(1'b0, rb);
    check("read again 1", rb, 8'h2A);
    mst.recv_byte(1'b1, rb);
    mst.bus_stop();
    check("read again 2", rb, 8'h2A);
    $display("test refusal done");
    k = 0;
    fork
      begin
        mst.bus_start();
        put({DEV, 1'b0});
        put(8'h00);
        put(8'h41);
        put(8'h42);
        mst.bus_stop();
      end
      begin
        for (w = 0; w < 2000 && fastSourceSelect !== 4'h1; w++) @(negedge clk);
        for (k = 0; k < 300 && fastSourceSelect !== 4'h2; k++) @(negedge clk);
      end
    join
    check("window", (k >= FDLY - 2) && (k <= FDLY + 4), 1'b1);
    $display("test window done");
    rst = 1'b1;
    repeat (16) @(negedge clk);
    rst = 1'b0;
    repeat (8) @(negedge clk);
    check("reset pins", serialControl, 1'b0);
    check("reset route", fastLaneRoute, 16'h7654);
    check("reset eq", inputEqLevel, 16'hFFFF);
    check("reset sda", sdaOeN, 1'b1);
    $display("test reset done");
    tally_and_finish();
  end
endmodule
